// ===== logic/sesc_host.sv
/*
 Host controller that programs and polls the memory's EDAC control logic
 over its strobe and address pins, ordered by software over APB.
 Assumes pins from the memory are asynchronous and the APB master is on clk.
*/
// Operation
// - Controller may hold off accesses while scrub warning is low.
// - No access while scrub-active is low; controller must wait.
// - After scrub error, host may read counter to find word.
// - Config write: selects active, strobes high, flag high, A9 A10 low.
// - Config read: same strobes, A9 high, A10 low.
// - Counter read: same strobes, A7 and A10 high.
// - Host avoids every other A7 to A10 combination.
// - A10 and A9 held zero while programming config.
`timescale 1ns/1ps
module sesc_host
    import sesc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [ADDR_W-1:0] mem_addr,
    output logic chip_select_low_active,
    output logic chip_select_high_active,
    output logic output_enable_n,
    output logic write_strobe_n,
    input wire logic [31:0] dq_in,
    output logic [31:0] dq_out,
    output logic dq_oe_n,
    input wire logic error_flag_in,
    output logic error_flag_out,
    output logic error_flag_oe_n,
    input wire logic scrub_warning_n,
    input wire logic scrub_active_n
);
    typedef struct packed {
        sesc_state_t st;
        logic [3:0] cnt;
        sesc_op_t op;
        logic hold_en;
        logic [CFG_W-1:0] cfg;
        logic [31:0] rdata;
        logic cfg_ok;
        logic [1:0] warn_sy;
        logic [1:0] act_sy;
        logic [1:0] flag_sy;
        logic [31:0] dq_s1;
        logic [31:0] dq_s2;
        sesc_pins_t pins;
    } sesc_regs_t;

    localparam sesc_pins_t PINS_IDLE = '{addr: '0,
        chip_select_low_active: 1'b1, chip_select_high_active: 1'b0,
        output_enable_n: 1'b1, write_strobe_n: 1'b1,
        error_flag_oe_n: 1'b1};
    localparam sesc_regs_t REGS_RST = '{st: SESC_IDLE, cnt: '0,
        op: SESC_OP_NONE, hold_en: 1'b0, cfg: CFG_RST, rdata: '0,
        cfg_ok: 1'b0, warn_sy: 2'b11, act_sy: 2'b11, flag_sy: 2'b00,
        dq_s1: '0, dq_s2: '0, pins: PINS_IDLE};

    logic [1:0] rst_sy_r;
    logic rst_n;
    sesc_regs_t s_r;
    sesc_regs_t s_nxt;
    sesc_apb_req_t req;
    logic wr_en;
    logic act_hi;
    logic warn_hi;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sy_r <= 2'b00;
        else
            rst_sy_r <= {rst_sy_r[0], 1'b1};
    end
    assign rst_n = rst_sy_r[1];

    assign req = '{psel: psel, penable: penable, pwrite: pwrite,
        paddr: paddr, pwdata: pwdata};
    assign pready = 1'b1;
    assign wr_en = req.psel && req.penable && req.pwrite;
    assign act_hi = s_r.act_sy[1];
    assign warn_hi = s_r.warn_sy[1];

    always_comb
    begin
        unique case (req.paddr)
            OFS_CMD: prdata = {27'h0000000, s_r.hold_en, 2'b00, s_r.op};
            OFS_CFG: prdata = {19'h00000, s_r.cfg};
            OFS_STATUS: prdata = {27'h0000000, s_r.flag_sy[1], !act_hi,
                !warn_hi, s_r.cfg_ok, s_r.st != SESC_IDLE};
            OFS_RDATA: prdata = s_r.rdata;
            default: prdata = 32'h00000000;
        endcase
        pslverr = req.psel && req.penable && !(req.paddr == OFS_CMD
            || req.paddr == OFS_CFG || req.paddr == OFS_STATUS
            || req.paddr == OFS_RDATA);
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.warn_sy = {s_r.warn_sy[0], scrub_warning_n};
        s_nxt.act_sy = {s_r.act_sy[0], scrub_active_n};
        s_nxt.flag_sy = {s_r.flag_sy[0], error_flag_in};
        s_nxt.dq_s1 = dq_in;
        s_nxt.dq_s2 = s_r.dq_s1;
        if (wr_en && req.paddr == OFS_CFG && s_r.st == SESC_IDLE)
        begin
            s_nxt.cfg = req.pwdata[CFG_W-1:0];
            s_nxt.cfg_ok = 1'b0;
        end
        unique case (s_r.st)
            SESC_IDLE:
            begin
                if (wr_en && req.paddr == OFS_CMD
                    && req.pwdata[CMD_OP_LSB+:2] != SESC_OP_NONE)
                begin
                    s_nxt.op = sesc_op_t'(req.pwdata[CMD_OP_LSB+:2]);
                    s_nxt.hold_en = req.pwdata[CMD_HOLD_BIT];
                    s_nxt.st = SESC_WAIT;
                end
            end
            SESC_WAIT:
            begin
                // Start only while memory is accessible
                if (act_hi && !(s_r.hold_en && !warn_hi))
                begin
                    s_nxt.st = SESC_SETUP;
                    s_nxt.cnt = 4'(SETUP_CYC);
                    s_nxt.pins = PINS_IDLE;
                    s_nxt.pins.error_flag_oe_n = 1'b0;
                    unique case (s_r.op) // Defined selects only
                        SESC_OP_CFG_WR:
                        begin
                            // Config on address, A10 A9 low
                            s_nxt.pins.addr[CFG_W-1:0] = s_r.cfg & CFG_MASK;
                        end
                        SESC_OP_CFG_RD:
                        begin
                            s_nxt.pins.addr[A_RD_SEL] = 1'b1;
                        end
                        default:
                        begin
                            s_nxt.pins.addr[A_CNT_SEL] = 1'b1;
                            s_nxt.pins.addr[A_FN_SEL] = 1'b1;
                        end
                    endcase
                end
            end
            SESC_SETUP:
            begin
                if (s_r.cnt > 4'h1)
                    s_nxt.cnt = s_r.cnt - 4'h1;
                else
                begin
                    s_nxt.st = SESC_ACT;
                    s_nxt.cnt = 4'(ACCESS_CYC + SYNC_CYC);
                    s_nxt.pins.chip_select_low_active = 1'b0;
                    s_nxt.pins.chip_select_high_active = 1'b1;
                end
            end
            SESC_ACT:
            begin
                if (!act_hi)
                begin
                    // Scrub began: drop the access and retry
                    s_nxt.st = SESC_WAIT;
                    s_nxt.pins = PINS_IDLE;
                end
                else if (s_r.cnt > 4'h1)
                    s_nxt.cnt = s_r.cnt - 4'h1;
                else
                begin
                    s_nxt.st = SESC_RECOVER;
                    s_nxt.cnt = 4'(RECOVER_CYC);
                    s_nxt.pins.chip_select_low_active = 1'b1;
                    s_nxt.pins.chip_select_high_active = 1'b0;
                    if (s_r.op == SESC_OP_CFG_RD)
                    begin
                        // Read-back lands in written positions
                        s_nxt.rdata = s_r.dq_s2 & {19'h00000, CFG_MASK};
                        s_nxt.cfg_ok = (s_r.dq_s2[CFG_W-1:0] & CFG_MASK)
                            == (s_r.cfg & CFG_MASK);
                    end
                    else if (s_r.op == SESC_OP_CNT_RD)
                        s_nxt.rdata = s_r.dq_s2 & CNT_MASK;
                    else
                        s_nxt.cfg_ok = 1'b0;
                end
            end
            SESC_RECOVER:
            begin
                if (s_r.cnt > 4'h1)
                    s_nxt.cnt = s_r.cnt - 4'h1;
                else
                begin
                    s_nxt.st = SESC_IDLE;
                    s_nxt.op = SESC_OP_NONE;
                    s_nxt.pins = PINS_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = SESC_IDLE;
                s_nxt.pins = PINS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= REGS_RST;
        else
            s_r <= s_nxt;
    end

    assign mem_addr = s_r.pins.addr;
    assign chip_select_low_active = s_r.pins.chip_select_low_active;
    assign chip_select_high_active = s_r.pins.chip_select_high_active;
    assign output_enable_n = s_r.pins.output_enable_n;
    assign write_strobe_n = s_r.pins.write_strobe_n;
    assign error_flag_oe_n = s_r.pins.error_flag_oe_n;
    assign error_flag_out = 1'b1;
    assign dq_out = 32'h00000000;
    assign dq_oe_n = 1'b1;

    a_act_needs_scrub: assert property (@(posedge clk)
        disable iff (!rst_n)
        (s_r.st == SESC_ACT && !act_hi) |=> (s_r.st == SESC_WAIT
            && s_r.pins.chip_select_low_active))
        else $error("access not dropped during scrub");
    a_start_when_idle: assert property (@(posedge clk)
        disable iff (!rst_n)
        (s_r.st == SESC_WAIT && $past(s_r.st) == SESC_WAIT && !act_hi)
            |=> s_r.st == SESC_WAIT)
        else $error("access started while scrub active");
    a_warn_hold: assert property (@(posedge clk)
        disable iff (!rst_n)
        (s_r.st == SESC_WAIT && s_r.hold_en && !warn_hi)
            |=> s_r.st != SESC_SETUP)
        else $error("access started during warning hold");
    a_cfg_wr_pins: assert property (@(posedge clk)
        disable iff (!rst_n)
        (!s_r.pins.chip_select_low_active && s_r.op == SESC_OP_CFG_WR)
            |-> (s_r.pins.chip_select_high_active
            && s_r.pins.output_enable_n && s_r.pins.write_strobe_n
            && !s_r.pins.error_flag_oe_n
            && s_r.pins.addr[CFG_W-1:0] == (s_r.cfg & CFG_MASK)))
        else $error("bad config write pins");
    a_cfg_rd_sel: assert property (@(posedge clk)
        disable iff (!rst_n)
        (!s_r.pins.chip_select_low_active && s_r.op == SESC_OP_CFG_RD)
            |-> (s_r.pins.addr[A_RD_SEL] && !s_r.pins.addr[A_FN_SEL]
            && s_r.pins.write_strobe_n && s_r.pins.output_enable_n))
        else $error("bad config read select");
    a_cnt_rd_sel: assert property (@(posedge clk)
        disable iff (!rst_n)
        (!s_r.pins.chip_select_low_active && s_r.op == SESC_OP_CNT_RD)
            |-> (s_r.pins.addr[A_CNT_SEL] && s_r.pins.addr[A_FN_SEL]
            && !s_r.pins.error_flag_oe_n))
        else $error("bad counter read select");
    a_no_reserved: assert property (@(posedge clk)
        disable iff (!rst_n)
        !s_r.pins.chip_select_low_active |-> (!s_r.pins.addr[A_FN_SEL]
            || s_r.pins.addr[A_CNT_SEL]))
        else $error("reserved function select");
    a_prog_a10_a9: assert property (@(posedge clk)
        disable iff (!rst_n)
        (s_r.st == SESC_ACT && s_r.op == SESC_OP_CFG_WR)
            |-> (s_r.pins.addr[A_FN_SEL:A_RD_SEL] == 2'b00))
        else $error("A10 A9 not zero when programming");
    a_cnt_masked: assert property (@(posedge clk)
        disable iff (!rst_n)
        (s_r.st == SESC_ACT && s_r.op == SESC_OP_CNT_RD && act_hi
            && s_r.cnt == 4'h1) |=> (s_r.rdata[31:CNT_W] == '0
            && s_r.rdata == ($past(s_r.dq_s2) & CNT_MASK)))
        else $error("counter read not masked");
    a_cfg_ok_read: assert property (@(posedge clk)
        disable iff (!rst_n)
        $rose(s_r.cfg_ok) |-> ($past(s_r.op) == SESC_OP_CFG_RD
            && s_r.st == SESC_RECOVER))
        else $error("config confirmed without read-back");
endmodule : sesc_host

// ===== logic/sesc_pkg.sv
/*
 Constants, enumerations and carriers for the scrub control host.
 Assumes a 50 MHz clock and an APB master with 32-bit data.
*/
package sesc_pkg;
    localparam int CLK_MHZ = 50;
    localparam int SETUP_NS = 20;
    localparam int ACCESS_NS = 20;
    localparam int RECOVER_NS = 20;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_CYC = 2;
    localparam logic [11:0] OFS_CMD = 12'h000;
    localparam logic [11:0] OFS_CFG = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_RDATA = 12'h00C;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_HOLD_BIT = 4;
    localparam int CFG_W = 13;
    localparam logic [12:0] CFG_RST = 13'h0000;
    localparam logic [12:0] CFG_MASK = 13'h19FF;
    localparam int CFG_BYPASS_BIT = 8;
    localparam int CFG_SCRUB_OFF_BIT = 11;
    localparam int CFG_FLAG_SEL_BIT = 12;
    localparam int A_CNT_SEL = 7;
    localparam int A_RD_SEL = 9;
    localparam int A_FN_SEL = 10;
    localparam int ADDR_W = 19;
    localparam int CNT_W = 19;
    localparam logic [31:0] CNT_MASK = 32'h0007FFFF;
    localparam int ST_BUSY = 0;
    localparam int ST_CFG_OK = 1;
    localparam int ST_WARN = 2;
    localparam int ST_SCRUB = 3;
    localparam int ST_FLAG = 4;

    typedef enum logic [1:0] {
        SESC_OP_NONE = 2'b00,
        SESC_OP_CFG_WR = 2'b01,
        SESC_OP_CFG_RD = 2'b10,
        SESC_OP_CNT_RD = 2'b11
    } sesc_op_t;

    typedef enum logic [2:0] {
        SESC_IDLE = 3'b000,
        SESC_WAIT = 3'b001,
        SESC_SETUP = 3'b010,
        SESC_ACT = 3'b011,
        SESC_RECOVER = 3'b100
    } sesc_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic chip_select_low_active;
        logic chip_select_high_active;
        logic output_enable_n;
        logic write_strobe_n;
        logic error_flag_oe_n;
    } sesc_pins_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sesc_apb_req_t;
endpackage : sesc_pkg

// ===== sim/sesc_mem_model.sv
/*
 Behavioural master-role memory control logic for the scrub host bench.
 Assumes the bench resolves the shared error flag line and kicks scrubs.
*/
`timescale 1ns/1ps
module sesc_mem_model
    import sesc_pkg::*;
#(
    parameter bit MASTER = 1'b1
)
(
    input wire logic [ADDR_W-1:0] addr,
    input wire logic chip_select_low_active,
    input wire logic chip_select_high_active,
    input wire logic output_enable_n,
    input wire logic write_strobe_n,
    input wire logic error_flag,
    input wire logic kick,
    input wire logic inject,
    output logic [31:0] dq,
    output logic error_flag_drv,
    output logic error_flag_oe_n,
    output logic scrub_warning_n,
    output logic scrub_active_n
);
    // Power-up contents are arbitrary
    logic [CFG_W-1:0] cfg_r = 13'h1555;
    logic [CNT_W-1:0] cnt_r = '0;
    logic [31:0] junk = 32'hA5A50F0F;
    // Control access decode
    wire ctl = !chip_select_low_active && chip_select_high_active &&
        output_enable_n && write_strobe_n && error_flag && scrub_active_n;

    initial
    begin
        scrub_warning_n = 1'b1;
        scrub_active_n = 1'b1;
        error_flag_oe_n = 1'b1;
        error_flag_drv = 1'b0;
    end
    always #7 junk = {junk[30:0], ~junk[31]};
    always @(posedge ctl)
        if (!addr[A_FN_SEL] && !addr[A_RD_SEL])
        begin
            cfg_r = addr[CFG_W-1:0];
            cnt_r = '1;
        end
    always_comb
        if (ctl && !addr[A_FN_SEL] && addr[A_RD_SEL])
            dq = {junk[31:CFG_W], cfg_r};
        else if (ctl && addr[A_FN_SEL] && addr[A_CNT_SEL])
            dq = {junk[31:CNT_W], cnt_r};
        else
            dq = junk;
    // Scrub engine, started by the bench in place of the rate timer
    always @(posedge kick)
        // Only a master with correction and scrub on
        if (MASTER && !cfg_r[CFG_BYPASS_BIT] && !cfg_r[CFG_SCRUB_OFF_BIT])
        begin
            #3 scrub_warning_n = 1'b0;
            #(80 + 40 * cfg_r[7:4]);
            scrub_active_n = 1'b0;
            cnt_r = cnt_r + 1'b1;
            // Single-bit upset flagged
            error_flag_drv = inject && cfg_r[CFG_FLAG_SEL_BIT];
            error_flag_oe_n = 1'b0;
            #600;
            error_flag_oe_n = 1'b1;
            scrub_active_n = 1'b1;
            scrub_warning_n = 1'b1;
        end
endmodule : sesc_mem_model

// ===== sim/tb_top.sv
/*
 Self-checking bench for the scrub control host, driven over APB.
 Assumes sesc_mem_model on the memory pins and a 50 MHz clock.
*/
`timescale 1ns/1ps
module tb_top
    import sesc_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, dq_out, m_dq, q, v;
    logic pready, pslverr, cs_lo, cs_hi, oe_n, we_n, dq_oe_n;
    logic ef_out, ef_oe_n, m_ef, m_ef_oe_n, m_warn_n, m_scrub_n, ef_line;
    logic ef_last = 1'b0;
    logic kick = 1'b0;
    logic inject = 1'b0;
    logic [ADDR_W-1:0] mem_addr;
    logic [64:0] exp_q[$];
    logic [64:0] mon_n;
    int errors = 0;
    int samples_checked = 0;
    int seed = 6708;
    int i, k;

    initial
    begin
        forever #10 clk = ~clk;
    end
    // Flag line floats to a changing level when nobody drives it
    assign ef_line = !ef_oe_n ? ef_out : !m_ef_oe_n ? m_ef : ~ef_last;
    always @(posedge clk) ef_last <= (ef_line === 1'b1);

    sesc_host sesc_host_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_addr(mem_addr), .chip_select_low_active(cs_lo),
        .chip_select_high_active(cs_hi), .output_enable_n(oe_n),
        .write_strobe_n(we_n), .dq_in(!dq_oe_n ? dq_out : m_dq),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .error_flag_in(ef_line),
        .error_flag_out(ef_out), .error_flag_oe_n(ef_oe_n),
        .scrub_warning_n(m_warn_n), .scrub_active_n(m_scrub_n));
    sesc_mem_model sesc_mem_model_inst (.addr(mem_addr),
        .chip_select_low_active(cs_lo), .chip_select_high_active(cs_hi),
        .output_enable_n(oe_n), .write_strobe_n(we_n), .error_flag(ef_line),
        .kick(kick), .inject(inject), .dq(m_dq), .error_flag_drv(m_ef),
        .error_flag_oe_n(m_ef_oe_n), .scrub_warning_n(m_warn_n),
        .scrub_active_n(m_scrub_n));

    task automatic close_out();
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    // One APB transfer; m masks the read data compared, e is pslverr
    task automatic acc(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] m, input logic e,
        input logic [31:0] x);
        exp_q.push_back({m, e, x});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : acc

    // Command an operation and poll until it is no longer busy
    task automatic run(input logic [31:0] c);
        acc(1'b1, OFS_CMD, c, '0, 1'b0, '0);
        q = 32'h1;
        for (k = 0; k < 200 && q[ST_BUSY] !== 1'b0; k++)
            acc(1'b0, OFS_STATUS, '0, '0, 1'b0, '0);
        if (q[ST_BUSY] !== 1'b0)
        begin
            errors++;
            $display("MISMATCH %0t operation never finished", $time);
        end
    endtask : run

    task automatic scrub(input logic inj);
        inject <= inj;
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
    endtask : scrub

    task automatic wait_lo(input logic s);
        for (k = 0; k < 200 && (s ? m_scrub_n : m_warn_n) !== 1'b0; k++)
            @(posedge clk);
    endtask : wait_lo

    always @(posedge clk)
        if (psel && penable && pready === 1'b1)
        begin
            mon_n = exp_q.pop_front();
            samples_checked++;
            if (pslverr !== mon_n[32] ||
                (prdata & mon_n[64:33]) !== (mon_n[31:0] & mon_n[64:33]))
            begin
                errors++;
                $display("MISMATCH %0t at %h read %h", $time, paddr, prdata);
            end
        end

    initial
    begin
        #400000;
        errors++;
        close_out();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        acc(1'b0, OFS_CFG, '0, '1, 1'b0, '0);
        acc(1'b0, 12'h010, '0, '1, 1'b1, '0);
        acc(1'b1, 12'hFF0, '1, '0, 1'b1, '0);
        for (i = 0; i < 5; i++)
        begin
            v = (i == 4) ? 32'h1FFF : $random(seed);
            acc(1'b1, OFS_CFG, v, '0, 1'b0, '0);
            run(32'h1);
            run(32'h2);
            acc(1'b0, OFS_RDATA, '0, '1, 1'b0, v & 32'h19FF);
            acc(1'b0, OFS_STATUS, '0, 32'h3, 1'b0, 32'h2);
            run(32'h3);
            acc(1'b0, OFS_RDATA, '0, '1, 1'b0, 32'h7FFFF);
        end
        for (i = 0; i < 2; i++)
        begin
            acc(1'b1, OFS_CFG, i ? 32'h800 : 32'h100, '0, 1'b0, '0);
            run(32'h1);
            scrub(1'b0);
            repeat (80) @(posedge clk);
            run(32'h3);
            acc(1'b0, OFS_RDATA, '0, '1, 1'b0, 32'h7FFFF);
        end
        v = ($random(seed) & 32'h100F) | 32'h10F0;
        acc(1'b1, OFS_CFG, v, '0, 1'b0, '0);
        run(32'h1);
        scrub(1'b1);
        wait_lo(1'b0);
        run(32'h2);
        acc(1'b0, OFS_RDATA, '0, '1, 1'b0, v);
        wait_lo(1'b1);
        repeat (4) @(posedge clk);
        acc(1'b0, OFS_STATUS, '0, 32'h1C, 1'b0, 32'h1C);
        run(32'h13);
        acc(1'b0, OFS_RDATA, '0, '1, 1'b0, '0);
        scrub(1'b0);
        wait_lo(1'b0);
        run(32'h13);
        acc(1'b0, OFS_RDATA, '0, '1, 1'b0, 32'h1);
        close_out();
    end
endmodule : tb_top
